// ---- vpc_top.sv ----
// Voice phrase playback control: phrase transfer, ROM fetch, decode.
// Assumes host control bits come from logic on the same 40 MHz clock.
// Contract
// - Seven sample rates from 2.048 MHz clock
// - Sample rates scale with input clock
// - Crystal clock halved, RC clock used directly
// - Tone pins low at reset, then complementary; code keeps both low until ROUTE_TONE_SELECT_I has been high
// - Busy output low only while playing
// - Enable pin mirrors run bit, resets section
// - Codes 01 to F7 select phrases
// - All-zero code stops output, converter mid
// - Stop during playback releases busy high
// - Play start to end address, then stop
// - Three decoding methods selected per phrase
// - ADPCM adapts step every 4-bit sample
// - Nonlinear PCM finer near waveform centre
// - Transfer starts on strobe falling edge
// - Next-ready low until prior sound ends
// - Interrupt rate 128 Hz or 4 kHz
// - Monitors show busy and next-ready, reset one
`timescale 1ns/1ps
`include "vpc_regs.svh"
module vpc_top
    import vpc_pkg::*;
#(
    parameter int OSC_XTAL_HZ = `VPC_OSC_XTAL_HZ,
    parameter int OSC_RC_HZ = `VPC_SECT_HZ
)
(
    input wire logic SYS_CLK_I,                // 40 MHz clock
    input wire logic RESET_I,                  // Sync reset, high
    input wire logic XTAL_MODE_I,              // 1 crystal, 0 RC
    input wire logic SYNTH_RUN_BIT_I,          // Section out of reset
    input wire logic SYNTH_SELECT_N_I,         // Chip select, low
    input wire logic TRANSFER_STROBE_I,        // Transfer strobe
    input wire logic [3:0] PHRASE_HIGH_NIBBLE_I, // Code bits 7..4
    input wire logic [3:0] PHRASE_LOW_NIBBLE_I,  // Code bits 3..0
    input wire logic SYNTH_OR_XFER_SELECT_I,   // 0 voice synthesis
    input wire logic ROM_SOURCE_SELECT_I,      // 0 internal, 1 ext
    input wire logic IRQ_RATE_SELECT_I,        // 0 128 Hz, 1 4 kHz
    input wire logic ROUTE_TONE_SELECT_I,      // Tone output state
    input wire logic ROUTE_SOURCE_SELECT_I,    // 1 blocks core tone
    input wire logic MCU_TONE_I,               // Core tone level
    input wire logic [7:0] ROM_DATA_I,         // ROM read byte
    input wire logic ROM_VALID_I,              // ROM byte valid
    output logic ROM_REQ_O,                    // ROM read request
    output logic [18:0] ROM_ADDR_O,            // ROM byte address
    output logic ROM_EXT_SEL_O,                // External ROM used
    output logic [11:0] CONVERTER_OUT_O,       // Converter code
    output logic TONE_OUT_TRUE_O,              // Tone output
    output logic TONE_OUT_INVERTED_O,          // Inverse tone
    output logic PLAYBACK_ACTIVE_N_O,          // Busy, low
    output logic SYNTH_SECTION_ENABLE_O,       // Enable pin
    output logic PLAYBACK_ACTIVE_MON_O,        // Busy monitor
    output logic NEXT_PHRASE_READY_MON_O,      // Next-ready monitor
    output logic SAMPLE_IRQ_O                  // Interrupt pulse
);
    vpc_state_t state_reg;
    logic srst;
    logic [31:0] acc_reg;
    logic [32:0] acc_sum;
    logic osc_tick_reg;
    logic half_reg;
    logic sect_tick;
    logic strobe_d_reg;
    logic strobe_fall;
    logic [3:0] xfer_cnt_reg;
    logic [7:0] sh_reg;
    logic [7:0] rx_reg;
    logic xfer_done_reg;
    logic is_stop;
    logic is_user;
    logic pend_reg;
    logic [7:0] pend_code_reg;
    logic nrdy_reg;
    logic req_reg;
    logic [18:0] addr_reg;
    logic [18:0] start_reg;
    logic [18:0] end_reg;
    logic [2:0] idx_reg;
    logic [1:0] meth_reg;
    logic [2:0] rate_reg;
    logic ext_reg;
    logic fetch_done_reg;
    logic [9:0] samp_cnt_reg;
    logic [9:0] samp_div;
    logic samp_tick;
    logic play_end;
    logic nib_reg;
    logic [7:0] hold_reg;
    logic signed [11:0] pcm_reg;
    logic [11:0] step_reg;
    logic [11:0] dac_reg;
    logic [13:0] irq_cnt_reg;
    logic irq_reg;
    logic busy_n_reg;
    logic en_reg;
    logic tone_on_reg;
    logic tone_t_reg;
    logic tone_i_reg;
    logic [3:0] nib;
    logic [15:0] prod;
    logic signed [13:0] sum;
    logic signed [11:0] adp_val;
    logic [11:0] step_next;
    logic [6:0] mag;
    logic [11:0] lin;
    logic signed [11:0] dec_val;

    vpc_stream_if #(.W(8)) fill_s ();
    vpc_stream_if #(.W(8)) drain_s ();

    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RESET_I);

    // run bit low holds section in reset
    assign srst = RESET_I | ~SYNTH_RUN_BIT_I;

    assign acc_sum = {1'b0, acc_reg}
        + (XTAL_MODE_I ? 33'(OSC_XTAL_HZ) : 33'(OSC_RC_HZ));
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            acc_reg <= '0;
            osc_tick_reg <= 1'b0;
            half_reg <= 1'b0;
        end
        else
        begin
            osc_tick_reg <= acc_sum >= 33'(`VPC_SYS_HZ);
            acc_reg <= (acc_sum >= 33'(`VPC_SYS_HZ))
                ? 32'(acc_sum - 33'(`VPC_SYS_HZ)) : acc_sum[31:0];
            if (osc_tick_reg)
                half_reg <= ~half_reg;
        end
    end
    // crystal ticks halved, RC ticks direct
    assign sect_tick = osc_tick_reg & (~XTAL_MODE_I | half_reg);

    // falling strobe with select starts shift
    assign strobe_fall = strobe_d_reg & ~TRANSFER_STROBE_I
        & ~SYNTH_SELECT_N_I & ~srst;
    always_ff @(posedge SYS_CLK_I)
    begin
        if (srst)
        begin
            strobe_d_reg <= 1'b0;
            xfer_cnt_reg <= '0;
            sh_reg <= '0;
            rx_reg <= '0;
            xfer_done_reg <= 1'b0;
        end
        else
        begin
            strobe_d_reg <= TRANSFER_STROBE_I;
            xfer_done_reg <= 1'b0;
            if (strobe_fall)
            begin
                sh_reg <= {PHRASE_HIGH_NIBBLE_I, PHRASE_LOW_NIBBLE_I};
                xfer_cnt_reg <= `VPC_XFER_BITS;
            end
            else if (xfer_cnt_reg != '0 && sect_tick)
            begin
                rx_reg <= {rx_reg[6:0], sh_reg[7]};
                sh_reg <= {sh_reg[6:0], 1'b0};
                xfer_cnt_reg <= xfer_cnt_reg - 4'h1;
                xfer_done_reg <= xfer_cnt_reg == 4'h1;
            end
        end
    end

    assign is_stop = rx_reg == `VPC_STOP_CODE;
    assign is_user = !is_stop && rx_reg <= `VPC_PHR_LAST;

    // Phrase sequencing and ROM fetch
    always_ff @(posedge SYS_CLK_I)
    begin
        if (srst)
        begin
            state_reg <= ST_IDLE;
            pend_reg <= 1'b0;
            pend_code_reg <= '0;
            nrdy_reg <= 1'b1;
            req_reg <= 1'b0;
            addr_reg <= '0;
            start_reg <= '0;
            end_reg <= '0;
            idx_reg <= '0;
            meth_reg <= `VPC_METH_ADPCM;
            rate_reg <= '0;
            ext_reg <= 1'b0;
            fetch_done_reg <= 1'b0;
        end
        else if (xfer_done_reg && is_stop)
        begin
            state_reg <= ST_IDLE;
            pend_reg <= 1'b0;
            nrdy_reg <= 1'b1;
            req_reg <= 1'b0;
        end
        else if (xfer_done_reg && is_user && !SYNTH_OR_XFER_SELECT_I
            && state_reg == ST_IDLE)
        begin
            state_reg <= ST_HDR;
            addr_reg <= {8'h00, rx_reg, 3'h0};
            idx_reg <= '0;
            ext_reg <= ROM_SOURCE_SELECT_I;
            fetch_done_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_HDR:
                begin
                    if (!req_reg && !ROM_VALID_I)
                        req_reg <= 1'b1;
                    else if (req_reg && ROM_VALID_I)
                    begin
                        req_reg <= 1'b0;
                        idx_reg <= idx_reg + 3'h1;
                        addr_reg <= addr_reg + 19'h1;
                        case (idx_reg)
                            3'h0:
                            begin
                                meth_reg <= ROM_DATA_I[`VPC_HDR_METH_LSB +: 2];
                                rate_reg <= ROM_DATA_I[2:0];
                            end
                            3'h1: start_reg[18:16] <= ROM_DATA_I[2:0];
                            3'h2: start_reg[15:8] <= ROM_DATA_I;
                            3'h3: start_reg[7:0] <= ROM_DATA_I;
                            3'h4: end_reg[18:16] <= ROM_DATA_I[2:0];
                            3'h5: end_reg[15:8] <= ROM_DATA_I;
                            default: end_reg[7:0] <= ROM_DATA_I;
                        endcase
                        if (idx_reg == `VPC_HDR_LAST)
                        begin
                            state_reg <= ST_PLAY;
                            addr_reg <= start_reg;
                        end
                    end
                end
                ST_PLAY:
                begin
                    // sequential fetch up to end address
                    if (!req_reg && !ROM_VALID_I && !fetch_done_reg
                        && fill_s.ready)
                        req_reg <= 1'b1;
                    else if (req_reg && ROM_VALID_I)
                    begin
                        req_reg <= 1'b0;
                        if (addr_reg == end_reg)
                            fetch_done_reg <= 1'b1;
                        else
                            addr_reg <= addr_reg + 19'h1;
                    end
                    if (play_end && pend_reg)
                    begin
                        state_reg <= ST_HDR;
                        addr_reg <= {8'h00, pend_code_reg, 3'h0};
                        idx_reg <= '0;
                        ext_reg <= ROM_SOURCE_SELECT_I;
                        fetch_done_reg <= 1'b0;
                        pend_reg <= 1'b0;
                        nrdy_reg <= 1'b1;
                    end
                    else if (play_end && !xfer_done_reg)
                    begin
                        state_reg <= ST_IDLE;
                        nrdy_reg <= 1'b1;
                    end
                end
                default: req_reg <= 1'b0;
            endcase
            if (xfer_done_reg && is_user && !SYNTH_OR_XFER_SELECT_I)
            begin
                pend_reg <= 1'b1;
                pend_code_reg <= rx_reg;
                nrdy_reg <= 1'b0;
            end
        end
    end

    assign fill_s.valid = req_reg && ROM_VALID_I && state_reg == ST_PLAY;
    assign fill_s.data = ROM_DATA_I;

    vpc_fifo2 #(.W(8), .DEPTH(2)) u_buf (
        .clk_i(SYS_CLK_I),
        .rst_i(srst),
        .flush_i(xfer_done_reg && is_stop),
        .in_s(fill_s),
        .out_s(drain_s)
    );

    // sample divisors from the section clock
    always_comb
    begin
        case (rate_reg)
            3'h0: samp_div = `VPC_DIV_4K0;
            3'h1: samp_div = `VPC_DIV_5K3;
            3'h2: samp_div = `VPC_DIV_6K4;
            3'h3: samp_div = `VPC_DIV_8K0;
            3'h4: samp_div = `VPC_DIV_10K7;
            3'h5: samp_div = `VPC_DIV_12K8;
            default: samp_div = `VPC_DIV_16K0;
        endcase
    end
    assign samp_tick = sect_tick && samp_cnt_reg == '0;
    assign play_end = state_reg == ST_PLAY && samp_tick && !nib_reg
        && fetch_done_reg && !drain_s.valid;
    assign drain_s.ready = state_reg == ST_PLAY && samp_tick
        && !(meth_reg == `VPC_METH_ADPCM && nib_reg);

    always_comb
    begin
        // step scaled by magnitude, adapted each sample
        nib = nib_reg ? hold_reg[7:4] : drain_s.data[3:0];
        prod = step_reg * {nib[2:0], 1'b1};
        sum = nib[3] ? 14'(pcm_reg) - 14'(prod[15:3])
                     : 14'(pcm_reg) + 14'(prod[15:3]);
        adp_val = (sum > `VPC_PCM_MAX) ? 12'sh7FF
                : (sum < `VPC_PCM_MIN) ? -12'sh800 : sum[11:0];
        if (nib[2])
            step_next = (step_reg >= (`VPC_STEP_MAX >> 1))
                ? `VPC_STEP_MAX : {step_reg[10:0], 1'b0};
        else
            step_next = (step_reg - (step_reg >> 3) < `VPC_STEP_MIN)
                ? `VPC_STEP_MIN : step_reg - (step_reg >> 3);
        // fine steps near centre, coarse beyond knee
        mag = drain_s.data[6:0];
        if (mag < `VPC_NL_KNEE)
            lin = {3'h0, mag, 2'h0};
        else
            lin = {mag - `VPC_NL_OFS, 5'h00};
        if (lin > `VPC_STEP_MAX)
            lin = `VPC_STEP_MAX;
        case (meth_reg)
            `VPC_METH_ADPCM: dec_val = adp_val;
            `VPC_METH_STRAIGHT: dec_val = {~drain_s.data[7],
                drain_s.data[6:0], 4'h0};
            default: dec_val = drain_s.data[7] ? -lin : lin;
        endcase
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (srst)
        begin
            samp_cnt_reg <= '0;
            nib_reg <= 1'b0;
            hold_reg <= '0;
            pcm_reg <= '0;
            step_reg <= `VPC_STEP_MIN;
            dac_reg <= RESET_I ? `VPC_DAC_RST : `VPC_DAC_MID;
        end
        else
        begin
            if (sect_tick)
                samp_cnt_reg <= (samp_cnt_reg == '0)
                    ? samp_div - 10'h1 : samp_cnt_reg - 10'h1;
            if ((xfer_done_reg && is_stop) || play_end)
            begin
                dac_reg <= `VPC_DAC_MID;
                pcm_reg <= '0;
                step_reg <= `VPC_STEP_MIN;
                nib_reg <= 1'b0;
            end
            else if (drain_s.ready && drain_s.valid)
            begin
                hold_reg <= drain_s.data;
                nib_reg <= meth_reg == `VPC_METH_ADPCM;
                pcm_reg <= dec_val;
                dac_reg <= {~dec_val[11], dec_val[10:0]};
                if (meth_reg == `VPC_METH_ADPCM)
                    step_reg <= step_next;
            end
            else if (state_reg == ST_PLAY && samp_tick && nib_reg)
            begin
                nib_reg <= 1'b0;
                pcm_reg <= adp_val;
                dac_reg <= {~adp_val[11], adp_val[10:0]};
                step_reg <= step_next;
            end
        end
    end

    // interrupt rate select, 128 Hz default
    always_ff @(posedge SYS_CLK_I)
    begin
        if (srst)
        begin
            irq_cnt_reg <= '0;
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= sect_tick && irq_cnt_reg == '0;
            if (sect_tick)
                irq_cnt_reg <= (irq_cnt_reg != '0) ? irq_cnt_reg - 14'h1
                    : (IRQ_RATE_SELECT_I ? `VPC_IRQ_DIV_FAST
                                         : `VPC_IRQ_DIV_SLOW) - 14'h1;
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            busy_n_reg <= 1'b1;
            en_reg <= 1'b0;
            tone_on_reg <= 1'b0;
            tone_t_reg <= 1'b0;
            tone_i_reg <= 1'b0;
        end
        else
        begin
            busy_n_reg <= state_reg != ST_PLAY;
            en_reg <= SYNTH_RUN_BIT_I;
            if (ROUTE_TONE_SELECT_I)
                tone_on_reg <= 1'b1;
            tone_t_reg <= tone_on_reg & ~ROUTE_SOURCE_SELECT_I & MCU_TONE_I;
            tone_i_reg <= tone_on_reg
                & ~(~ROUTE_SOURCE_SELECT_I & MCU_TONE_I);
        end
    end

    assign PLAYBACK_ACTIVE_N_O = busy_n_reg;
    assign PLAYBACK_ACTIVE_MON_O = busy_n_reg;
    assign NEXT_PHRASE_READY_MON_O = nrdy_reg;
    assign SYNTH_SECTION_ENABLE_O = en_reg;
    assign CONVERTER_OUT_O = dac_reg;
    assign TONE_OUT_TRUE_O = tone_t_reg;
    assign TONE_OUT_INVERTED_O = tone_i_reg;
    assign SAMPLE_IRQ_O = irq_reg;
    assign ROM_REQ_O = req_reg;
    assign ROM_ADDR_O = addr_reg;
    assign ROM_EXT_SEL_O = ext_reg;

    property p_xtal_half;
        XTAL_MODE_I && $stable(XTAL_MODE_I) && sect_tick |=> !sect_tick;
    endproperty
    a_xtal_half: assert property (p_xtal_half)
        else $error("crystal section clock not halved");

    property p_busy;
        state_reg == ST_PLAY |=> !PLAYBACK_ACTIVE_N_O;
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy not low while playing");

    property p_enable;
        SYNTH_RUN_BIT_I |=> SYNTH_SECTION_ENABLE_O;
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable pin not following run bit");

    property p_stop_mid;
        !srst && xfer_done_reg && is_stop
            |=> state_reg == ST_IDLE && CONVERTER_OUT_O == `VPC_DAC_MID;
    endproperty
    a_stop_mid: assert property (p_stop_mid)
        else $error("stop code did not park converter");

    property p_stop_busy;
        SYNTH_RUN_BIT_I [*3] ##0 $past(xfer_done_reg, 2)
            && $past(is_stop, 2) |-> PLAYBACK_ACTIVE_N_O;
    endproperty
    a_stop_busy: assert property (p_stop_busy)
        else $error("busy not released after stop");

    property p_test_code;
        !srst && xfer_done_reg && !is_stop && !is_user
            && state_reg == ST_IDLE |=> state_reg == ST_IDLE;
    endproperty
    a_test_code: assert property (p_test_code)
        else $error("test code started playback");

    property p_next_low;
        !srst && xfer_done_reg && is_user && !SYNTH_OR_XFER_SELECT_I
            && state_reg != ST_IDLE ##1 !srst |-> !NEXT_PHRASE_READY_MON_O;
    endproperty
    a_next_low: assert property (p_next_low)
        else $error("next-ready high while prior sound plays");

    property p_step_range;
        step_reg >= `VPC_STEP_MIN && step_reg <= `VPC_STEP_MAX;
    endproperty
    a_step_range: assert property (p_step_range)
        else $error("ADPCM step out of range");

    property p_tone_inv;
        tone_on_reg ##1 tone_on_reg
            |-> TONE_OUT_INVERTED_O != TONE_OUT_TRUE_O;
    endproperty
    a_tone_inv: assert property (p_tone_inv)
        else $error("tone outputs not complementary");
endmodule

// ---- vpc_regs.svh ----
// Constants of the voice phrase playback block.
// Assumes a 40 MHz system clock; counts are in that clock or section ticks.
`ifndef VPC_REGS_SVH
`define VPC_REGS_SVH
`define VPC_SYS_HZ 40000000
`define VPC_OSC_XTAL_HZ 4096000
`define VPC_SECT_HZ 2048000
`define VPC_STOP_CODE 8'h00
`define VPC_PHR_LAST 8'hF7
`define VPC_XFER_BITS 4'h8
`define VPC_HDR_LAST 3'h6
`define VPC_DAC_RST 12'hFFF
`define VPC_DAC_MID 12'h800
`define VPC_STEP_MIN 12'h010
`define VPC_STEP_MAX 12'h7FF
`define VPC_PCM_MAX 14'sh07FF
`define VPC_PCM_MIN (-14'sh0800)
`define VPC_NL_KNEE 7'h40
`define VPC_NL_OFS 7'h38
`define VPC_METH_ADPCM 2'h0
`define VPC_METH_STRAIGHT 2'h1
`define VPC_METH_NONLIN 2'h2
`define VPC_HDR_METH_LSB 4
`define VPC_IRQ_DIV_SLOW 14'h3E80
`define VPC_IRQ_DIV_FAST 14'h0200
`define VPC_DIV_4K0 10'h200
`define VPC_DIV_5K3 10'h180
`define VPC_DIV_6K4 10'h140
`define VPC_DIV_8K0 10'h100
`define VPC_DIV_10K7 10'h0C0
`define VPC_DIV_12K8 10'h0A0
`define VPC_DIV_16K0 10'h080
`endif

// ---- vpc_pkg.sv ----
// Types shared by the voice phrase playback block.
// Assumes the constants header is included by each design file.
package vpc_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_PLAY} vpc_state_t;
endpackage

// ---- vpc_stream_if.sv ----
// Byte stream with valid and ready between fetch, buffer and decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface vpc_stream_if #(parameter int W = 8) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- vpc_fifo2.sv ----
// Small buffer between the ROM fetcher and the sample decoder.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
module vpc_fifo2 #(
    parameter int W = 8,
    parameter int DEPTH = 2
)
(
    input wire logic clk_i,    // System clock
    input wire logic rst_i,    // Synchronous reset
    input wire logic flush_i,  // Drop all entries
    vpc_stream_if.snk in_s,    // Filling side
    vpc_stream_if.src out_s    // Draining side
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign in_s.ready = cnt_reg != (AW+1)'(DEPTH);
    assign out_s.valid = cnt_reg != '0;
    assign out_s.data = mem_reg[rp_reg];
    assign push = in_s.valid & in_s.ready;
    assign pop = out_s.valid & out_s.ready;

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_reg[wp_reg] <= in_s.data;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || flush_i)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
            if (pop)
                rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    property p_no_overfill;
        @(posedge clk_i) disable iff (rst_i)
        cnt_reg == (AW+1)'(DEPTH) |-> !in_s.ready;
    endproperty
    a_no_overfill: assert property (p_no_overfill)
        else $error("buffer accepts while full");

    property p_hold_head;
        @(posedge clk_i) disable iff (rst_i || flush_i)
        out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data);
    endproperty
    a_hold_head: assert property (p_hold_head)
        else $error("buffer head lost under stall");
endmodule

// ---- vpc_rom_model.sv ----
// ROM partner: answers fetch requests with headers and sample bytes.
// Assumes requests are held until the valid pulse.
`timescale 1ns/1ps
module vpc_rom_model (
    input wire logic clk_i,         // System clock
    input wire logic req_i,         // Read request
    input wire logic [18:0] addr_i, // Byte address
    output logic valid_o,           // Data valid pulse
    output logic [7:0] data_o       // Read byte
);
    logic [1:0] wait_reg;
    logic [7:0] byte_next;
    initial
    begin
        valid_o = 1'b0;
        data_o = 8'h5A;
        wait_reg = 2'h3;
    end
    // Header: straight PCM, fastest rate, 100 to 101 or 1FF
    always_comb
    begin
        case (addr_i[2:0])
            3'h0: byte_next = 8'h16;
            3'h2, 3'h5: byte_next = 8'h01;
            3'h6: byte_next = addr_i[3] ? 8'h01 : 8'hFF;
            default: byte_next = 8'h00;
        endcase
        if (addr_i[18:8] != 11'h000)
            byte_next = addr_i[7:0];
    end
    // Odd addresses answer fast, even ones slow; idle data flips
    always @(posedge clk_i)
    begin
        valid_o <= 1'b0;
        data_o <= ~data_o;
        if (!req_i || valid_o)
            wait_reg <= {~addr_i[0], 1'b1};
        else if (wait_reg != 2'h0)
            wait_reg <= wait_reg - 2'h1;
        else
        begin
            valid_o <= 1'b1;
            data_o <= byte_next;
        end
    end
endmodule

// ---- vpc_top_tb.sv ----
// Bench for the playback block with a ROM partner.
// Assumes RC mode with a fast oscillator to shorten section ticks.
`timescale 1ns/1ps
module vpc_top_tb;
    logic clk = 0, rst = 1, run = 0, sel_n = 1, stb = 0, busy_d = 1;
    logic route = 0, tone = 0, irq_rate = 0, xtal = 0, xsel = 0, src = 0;
    logic [7:0] code = 8'h00;
    logic req, valid, n_busy, en, mon_b, mon_n, t_true, t_inv, ext, irq;
    logic [7:0] rdata;
    logic [18:0] raddr;
    logic [11:0] conv;
    logic [12:0] exp_q[$];
    logic [12:0] exp_v;
    int n_mismatch = 0, comparisons = 0, seed = 76, i, gap = -1;
    always #12.5 clk = ~clk;
    vpc_top #(.OSC_RC_HZ(20000000)) i_vpc_top (.SYS_CLK_I(clk),
        .RESET_I(rst), .XTAL_MODE_I(xtal), .SYNTH_RUN_BIT_I(run),
        .SYNTH_SELECT_N_I(sel_n), .TRANSFER_STROBE_I(stb),
        .PHRASE_HIGH_NIBBLE_I(code[7:4]), .PHRASE_LOW_NIBBLE_I(code[3:0]),
        .SYNTH_OR_XFER_SELECT_I(xsel), .ROM_SOURCE_SELECT_I(src),
        .IRQ_RATE_SELECT_I(irq_rate), .ROUTE_TONE_SELECT_I(route),
        .ROUTE_SOURCE_SELECT_I(1'b0), .MCU_TONE_I(tone),
        .ROM_DATA_I(rdata), .ROM_VALID_I(valid), .ROM_REQ_O(req),
        .ROM_ADDR_O(raddr), .ROM_EXT_SEL_O(ext), .CONVERTER_OUT_O(conv),
        .TONE_OUT_TRUE_O(t_true), .TONE_OUT_INVERTED_O(t_inv),
        .PLAYBACK_ACTIVE_N_O(n_busy), .SYNTH_SECTION_ENABLE_O(en),
        .PLAYBACK_ACTIVE_MON_O(mon_b), .NEXT_PHRASE_READY_MON_O(mon_n),
        .SAMPLE_IRQ_O(irq));
    vpc_rom_model i_vpc_rom_model (.clk_i(clk), .req_i(req),
        .addr_i(raddr), .valid_o(valid), .data_o(rdata));
    task automatic stop_test;
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, exp, input string nm);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic send(input logic [7:0] c);
        code = c;
        stb = 1'b1;
        @(posedge clk);
        #2 stb = 1'b0;
        repeat (40) @(posedge clk);
        #2;
    endtask
    task automatic wait_busy(input logic lvl);
        for (i = 0; i < 4000 && n_busy !== lvl; i++)
            @(posedge clk);
        #2 chk({11'h0, n_busy}, {11'h0, lvl}, "busy_wait");
        if (n_busy !== lvl)
            stop_test();
    endtask
    // Each busy change takes the oldest expected note
    always @(negedge clk)
        if (!rst && n_busy !== busy_d)
        begin
            busy_d = n_busy;
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 13'h1FFF;
            chk({11'h0, n_busy}, {11'h0, exp_v[12]}, "busy");
            chk({11'h0, mon_b}, {11'h0, exp_v[12]}, "busy_mon");
            if (n_busy === 1'b1)
                chk(conv, exp_v[11:0], "converter");
        end
    // Interrupt spacing: 512 section ticks of two clocks in RC mode
    always @(negedge clk)
        if (xtal || run !== 1'b1)
            gap = -1;
        else if (irq === 1'b1)
        begin
            if (gap >= 0)
                chk(12'(gap), 12'h3FF, "irq_gap");
            gap = 0;
        end
        else if (gap >= 0)
            gap++;
    initial
    begin
        repeat (5) @(posedge clk);
        #2 rst = 0;
        chk({n_busy, mon_b, mon_n, en, t_true, t_inv, 6'h0}, 12'hE00,
            "reset_pins");
        chk(conv, 12'hFFF, "conv_reset");
        run = 1'b1;
        irq_rate = 1'b1;
        repeat (2) @(posedge clk);
        #2 chk({11'h0, en}, 12'h001, "enable");
        sel_n = 1'b0;
        exp_q.push_back(13'h0000);
        exp_q.push_back({1'b1, 12'h800});
        send(8'h01);
        wait_busy(1'b0);
        chk({11'h0, ext}, 12'h000, "rom_int");
        wait_busy(1'b1);
        sel_n = 1'b1;
        send(8'h01);
        sel_n = 1'b0;
        xsel = 1'b1;
        send(8'h01);
        xsel = 1'b0;
        send(8'hF8);
        repeat (1500) @(posedge clk);
        #2 chk({11'h0, mon_n}, 12'h001, "ready_idle");
        exp_q.push_back(13'h0000);
        exp_q.push_back({1'b1, 12'h800});
        src = 1'b1;
        send(8'h02);
        wait_busy(1'b0);
        chk({11'h0, ext}, 12'h001, "rom_ext");
        send(8'h01);
        chk({11'h0, mon_n}, 12'h000, "ready_pending");
        send(8'h00);
        wait_busy(1'b1);
        chk({11'h0, mon_n}, 12'h001, "ready_stop");
        route = 1'b1;
        xtal = 1'b1;
        repeat (8)
        begin
            tone = $random(seed);
            repeat (3) @(posedge clk);
            #2 chk({11'h0, t_true ^ t_inv}, 12'h001, "tone_pair");
            chk({11'h0, t_true}, {11'h0, tone}, "tone_true");
        end
        run = 1'b0;
        repeat (2) @(posedge clk);
        #2 chk({11'h0, en}, 12'h000, "enable_off");
        chk({11'h0, exp_q.size() == 0}, 12'h001, "queue_empty");
        stop_test();
    end
endmodule
